// ===== rtl/sram_host_pkg.sv
// Purpose: Constants for the host controller of a 1M x 1 asynchronous static memory
// Assumes: Clock of 125 MHz (8 ns period)
// Notes: Times in picoseconds, cycle counts derived from them
package sram_host_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned READ_CYCLE_PS = 10000;
  localparam int unsigned WRITE_CYCLE_PS = 10000;
  localparam int unsigned ACCESS_PS = 10000;
  localparam int unsigned SELECT_TO_END_PS = 7000;
  localparam int unsigned DATA_SETUP_PS = 7000;
  localparam int unsigned RELEASE_PS = 5000;
  localparam int unsigned WRITE_FLOAT_PS = 6000;
  // Least times round up, never below one cycle
  function automatic int unsigned min_cycles(input int unsigned t_ps);
    int unsigned n;
    n = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (n < 1) ? 1 : n;
  endfunction
  localparam int unsigned READ_CYC = min_cycles(READ_CYCLE_PS);
  localparam int unsigned WRITE_CYC = min_cycles(WRITE_CYCLE_PS);
  // Data taken two cycles after the access time, after two sync flops
  localparam int unsigned ACCESS_CYC = min_cycles(ACCESS_PS);
  localparam int unsigned STROBE_CYC = min_cycles(SELECT_TO_END_PS);
  localparam int unsigned SETUP_CYC = min_cycles(DATA_SETUP_PS);
  localparam int unsigned RELEASE_CYC = min_cycles(RELEASE_PS);
  localparam int unsigned CNT_W = 4;
  typedef enum logic [2:0] {IDLE, RD_ACCESS, RD_SYNC, RD_GAP, WR_STROBE, WR_END} state_type;
endpackage

// ===== rtl/sram_host.sv
// Purpose: Host controller driving a 1M x 1 asynchronous static memory by its pins
// Assumes: Single request port; memory data output returns on an external pin
// Notes: All pin outputs come straight from flip-flops
`timescale 1ns/1ps
// Functional notes
// - Write strobe stays high through reads
// - Select and output gate low for reads
// - Write needs select and strobe both low
// - Address stable before select falls (code changes address and select on the same edge)
// - Read cycle lasts at least 10 ns
// - Write cycle lasts at least 10 ns
// - Select low 7 ns before write end
// - Write data stable 7 ns before end
module sram_host
  import sram_host_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [AW-1:0] req_addr_i,
  input wire logic req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic rsp_rdata_o,
  output logic [AW-1:0] mem_addr_o,
  output logic mem_select_n_o,
  output logic mem_write_n_o,
  output logic mem_gate_n_o,
  output logic mem_wdata_o,
  input wire logic mem_rdata_i
);
  // ==========================================================
  // Derived counts and elaboration checks
  localparam int unsigned WR_LOW_CYC = (STROBE_CYC > SETUP_CYC) ? STROBE_CYC : SETUP_CYC;
  // Cycles from a take to the earliest next address change
  localparam int unsigned RD_SPAN_CYC = ACCESS_CYC + RELEASE_CYC + 4;
  localparam int unsigned WR_SPAN_CYC = WR_LOW_CYC + RELEASE_CYC + 2;
  localparam int unsigned CNT_MAX = (1 << CNT_W) - 1;
  if (AW < 1 || AW > ADDR_W)
  begin
    $error("Address width out of range");
  end
  if (ACCESS_CYC > CNT_MAX || RELEASE_CYC > CNT_MAX || WR_LOW_CYC > CNT_MAX + 1)
  begin
    $error("Counter too narrow for the timing counts");
  end
  if (RD_SPAN_CYC < READ_CYC)
  begin
    $error("Read cycle shorter than allowed");
  end
  if (WR_SPAN_CYC < WRITE_CYC)
  begin
    $error("Write cycle shorter than allowed");
  end

  // ==========================================================
  // Pin input synchroniser
  logic rdata_meta_r;
  logic rdata_sync_r;
  always_ff @(posedge clock_i)
  begin
    rdata_meta_r <= mem_rdata_i;
    rdata_sync_r <= rdata_meta_r;
  end

  // ==========================================================
  // Sequencer
  state_type state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [AW-1:0] addr_nxt;
  logic select_n_nxt, write_n_nxt, gate_n_nxt, wdata_nxt;
  logic ready_nxt, rsp_valid_nxt, rsp_rdata_nxt;
  wire take = req_valid_i && req_ready_o;
  wire cnt_done = (cnt_r == '0);
  wire [CNT_W-1:0] cnt_dec = cnt_done ? cnt_r : cnt_r - 1'b1;

  // ==========================================================
  // Counter loads for each timed phase
  wire [CNT_W-1:0] rd_load = CNT_W'(ACCESS_CYC);
  wire [CNT_W-1:0] wr_load = CNT_W'(WR_LOW_CYC - 1);
  wire [CNT_W-1:0] gap_load = CNT_W'(RELEASE_CYC);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_dec;
    addr_nxt = mem_addr_o;
    select_n_nxt = mem_select_n_o;
    write_n_nxt = mem_write_n_o;
    gate_n_nxt = mem_gate_n_o;
    wdata_nxt = mem_wdata_o;
    ready_nxt = 1'b0;
    rsp_valid_nxt = 1'b0;
    rsp_rdata_nxt = rsp_rdata_o;
    case (state_r)
      IDLE:
      begin
        ready_nxt = 1'b1;
        if (take)
        begin
          ready_nxt = 1'b0;
          addr_nxt = req_addr_i;
          select_n_nxt = 1'b0;
          if (req_write_i)
          begin
            write_n_nxt = 1'b0;
            gate_n_nxt = 1'b1;
            wdata_nxt = req_wdata_i;
            cnt_nxt = wr_load;
            state_nxt = WR_STROBE;
          end
          else
          begin
            write_n_nxt = 1'b1;
            gate_n_nxt = 1'b0;
            cnt_nxt = rd_load;
            state_nxt = RD_ACCESS;
          end
        end
      end
      RD_ACCESS:
        if (cnt_done)
          state_nxt = RD_SYNC;
      RD_SYNC:
      begin
        if (cnt_done)
        begin
          rsp_valid_nxt = 1'b1;
          rsp_rdata_nxt = rdata_sync_r;
          select_n_nxt = 1'b1;
          gate_n_nxt = 1'b1;
          cnt_nxt = gap_load;
          state_nxt = RD_GAP;
        end
      end
      WR_STROBE:
        if (cnt_done)
        begin
          select_n_nxt = 1'b1;
          write_n_nxt = 1'b1;
          cnt_nxt = gap_load;
          rsp_valid_nxt = 1'b1;
          state_nxt = WR_END;
        end
      RD_GAP, WR_END:
        if (cnt_done)
        begin
          ready_nxt = 1'b1;
          state_nxt = IDLE;
        end
      default:
        state_nxt = IDLE;
    endcase
  end

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_r <= IDLE;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Memory pin registers
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      mem_addr_o <= '0;
      mem_select_n_o <= 1'b1;
      mem_write_n_o <= 1'b1;
      mem_gate_n_o <= 1'b1;
      mem_wdata_o <= 1'b0;
    end
    else
    begin
      mem_addr_o <= addr_nxt;
      mem_select_n_o <= select_n_nxt;
      mem_write_n_o <= write_n_nxt;
      mem_gate_n_o <= gate_n_nxt;
      mem_wdata_o <= wdata_nxt;
    end
  end

  // ==========================================================
  // Host response registers
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 1'b0;
    end
    else
    begin
      req_ready_o <= ready_nxt;
      rsp_valid_o <= rsp_valid_nxt;
      rsp_rdata_o <= rsp_rdata_nxt;
    end
  end
endmodule

// ===== tb/sram_host_props.sv
// Purpose: Pin checks
// Assumes: Sync reset
// Notes: Bound below
`timescale 1ns/1ps
module sram_host_props #(parameter int AW = 20)
(input logic clock_i, rst_i, rsp_valid_o, mem_select_n_o, mem_write_n_o, mem_gate_n_o,
 input logic mem_wdata_o, input logic [AW-1:0] mem_addr_o);
  wire s = mem_select_n_o, w = mem_write_n_o, g = mem_gate_n_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  rd_strobe_a: assert property (!g |-> w)
    else $error("rd strobe");
  rd_select_a: assert property (!g |-> !s)
    else $error("rd select");
  wr_select_a: assert property (!w |-> !s)
    else $error("wr select");
  addr_hold_a: assert property (!s && !$past(s) |-> $stable(mem_addr_o))
    else $error("addr moved");
  rd_cycle_a: assert property ($fell(g) |=> !g ##1 !g)
    else $error("rd short");
  wr_cycle_a: assert property ($fell(w) |=> $stable(mem_addr_o) [*2])
    else $error("wr short");
  sel_end_a: assert property ($rose(w) |-> !$past(s))
    else $error("select late");
  data_set_a: assert property ($rose(w) |-> $stable(mem_wdata_o))
    else $error("data late");
  cover property ($fell(g));
  cover property ($fell(w));
  cover property (rsp_valid_o);
endmodule
bind sram_host sram_host_props #(.AW(AW)) props (.clock_i(clock_i), .rst_i(rst_i),
  .rsp_valid_o(rsp_valid_o), .mem_select_n_o(mem_select_n_o),
  .mem_write_n_o(mem_write_n_o), .mem_gate_n_o(mem_gate_n_o),
  .mem_wdata_o(mem_wdata_o), .mem_addr_o(mem_addr_o));

// ===== tb/sram_dev.sv
// Purpose: 1M x 1 memory model
// Assumes: Host pins
// Notes: Released output shows inverse
`timescale 1ns/1ps
module sram_dev #(parameter int DLY = 10)
(input logic [19:0] addr_i, input logic sel_n_i, wr_n_i, gate_n_i, wdata_i,
 output logic rdata_o);
  bit m [0:1048575];
  bit last;
  wire en = !sel_n_i && wr_n_i && !gate_n_i;
  wire wr_end = sel_n_i | wr_n_i;
  always @(posedge wr_end) m[addr_i] = wdata_i;
  always @* if (en) last = m[addr_i];
  assign #DLY rdata_o = en ? m[addr_i] : ~last;
  // Output timing above also covers standby and re-drive
endmodule

// ===== tb/sram_host_tb_top.sv
// Purpose: Bench
// Assumes: 8 ns clock
// Notes: Model on pins
`timescale 1ns/1ps
module sram_host_tb_top;
  logic clock_i = 0, rst_i = 1, req_valid_i = 0, req_write_i = 0, req_wdata_i = 0;
  logic [19:0] req_addr_i = 0, mem_addr_o;
  logic req_ready_o, rsp_valid_o, rsp_rdata_o, mem_select_n_o, mem_write_n_o;
  logic mem_gate_n_o, mem_wdata_o, mem_rdata_i, r;
  int n_fail = 0, n_checks = 0, cyc = 0;
  always #4 clock_i = ~clock_i;
  sram_host dut (.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .mem_addr_o(mem_addr_o), .mem_select_n_o(mem_select_n_o),
    .mem_write_n_o(mem_write_n_o), .mem_gate_n_o(mem_gate_n_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));
  sram_dev mem (.addr_i(mem_addr_o), .sel_n_i(mem_select_n_o), .wr_n_i(mem_write_n_o),
    .gate_n_i(mem_gate_n_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  task automatic chk(input logic [19:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %0t %h %h", $time, s, e);
    end
  endtask
  task automatic op(input logic w, input logic [19:0] a, input logic d);
    repeat (40) if (req_ready_o !== 1'b1) @(posedge clock_i) #1;
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, w, a, d};
    @(posedge clock_i) #1 req_valid_i = 0;
    chk(req_ready_o, 1'b0);
    chk(mem_addr_o, a);
    chk({mem_select_n_o, mem_write_n_o, mem_gate_n_o}, w ? 3'h1 : 3'h2);
    if (w) chk(mem_wdata_o, d);
    repeat (40) if (rsp_valid_o !== 1'b1) @(posedge clock_i) #1;
    chk(rsp_valid_o, 1'b1);
    r = rsp_rdata_o;
    @(posedge clock_i) #1 chk(rsp_valid_o, 1'b0);
  endtask
  task automatic t_reset;
    repeat (40) if (req_ready_o !== 1'b1) @(posedge clock_i) #1;
    {req_valid_i, req_write_i, req_addr_i} = {1'b1, 1'b0, 20'h3};
    @(posedge clock_i) #1 req_valid_i = 0;
    rst_i = 1;
    repeat (2) @(posedge clock_i);
    #1 chk({mem_select_n_o, mem_write_n_o, mem_gate_n_o}, 3'h7);
    chk({req_ready_o, rsp_valid_o}, 2'h0);
    rst_i = 0;
    op(1, 20'h3, 1);
    op(0, 20'h3, 0);
    chk(r, 1'b1);
    $display("reset done");
  endtask
  task automatic t_edges;
    logic [19:0] ad [4] = '{20'h0, 20'hfffff, 20'h55555, 20'haaaaa};
    chk({mem_select_n_o, mem_write_n_o, mem_gate_n_o}, 3'h7);
    foreach (ad[i]) op(1, ad[i], i[0]);
    foreach (ad[i])
    begin
      op(0, ad[i], 0);
      chk(r, i[0]);
    end
    $display("edges done");
  endtask
  task automatic t_over;
    for (int v = 1; v >= 0; v--)
    begin
      op(1, 20'h1, v[0]);
      op(0, 20'h1, 0);
      chk(r, v[0]);
    end
    $display("overwrite done");
  endtask
  task print_verdict(input int extra);
    n_fail += extra;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock_i) if (++cyc == 1000) print_verdict(1);
  initial
  begin
    repeat (4) @(posedge clock_i);
    #1 rst_i = 0;
    t_edges;
    t_over;
    t_reset;
    print_verdict(0);
  end
endmodule
